// ===== hdl/sia_defines.vh
/*
 * constants for the shared indirect access register bank: register
 * offsets, field positions, reset values, target codes and timing.
 * assumes it is included by bare name from design files in hdl/.
 */
`ifndef SIA_DEFINES_VH
`define SIA_DEFINES_VH

// ********************************
// register offsets
// ********************************
`define SIA_OFF_CTL        8'hb0
`define SIA_OFF_ADDR       8'hb1
`define SIA_OFF_DATA       8'hb2
`define SIA_OFF_BIST       8'hb3
`define SIA_OFF_STRAP      8'hb8
`define SIA_OFF_PDCTL      8'hbe

// ********************************
// reset values
// ********************************
`define SIA_RST_CTL        6'h00
`define SIA_RST_ADDR       8'h00
`define SIA_RST_DATA       8'h00
`define SIA_RST_BIST       8'h08
`define SIA_RST_PD         3'h0

// ********************************
// field positions
// ********************************
`define SIA_CTL_SEL_HI     5
`define SIA_CTL_SEL_LO     2
`define SIA_CTL_AINC       1
`define SIA_CTL_RDEN       0
`define SIA_BIST_MODE_HI   7
`define SIA_BIST_MODE_LO   6
`define SIA_BIST_PINCFG    3
`define SIA_BIST_CSRC_HI   2
`define SIA_BIST_CSRC_LO   1
`define SIA_SELF_TEST_ENABLE        0

// ********************************
// target select codes
// ********************************
`define SIA_TGT_PORT0      4'h1
`define SIA_TGT_PORT1      4'h2
`define SIA_TGT_SHARED     4'h5
`define SIA_TGT_BOTH       4'h6

// ********************************
// self-test output modes and remote offset
// ********************************
`define SIA_OMODE_STATIC   2'h0
`define SIA_OMODE_ALT      2'h1
`define SIA_REM_CSRC_OFF   8'h14

// ********************************
// strap settling: a strap change is held this long before it is latched
// ********************************
`define SIA_STRAP_SETTLE_NS   1000
`define SIA_CLK_NS            40
`define SIA_STRAP_CYC  ((`SIA_STRAP_SETTLE_NS + `SIA_CLK_NS - 1) / `SIA_CLK_NS)
`define SIA_STRAP_CW          6

`endif

// ===== hdl/sia_strap_latch.v
/*
 * strap decoder: synchronises a 3-bit strap decode from pins, waits
 * for it to be stable, latches it and raises a done flag.
 * assumes the strap code is static after power-up and comes from pins.
 */
`timescale 1ns/1ns
`include "sia_defines.vh"

module sia_strap_latch (
  clock,
  rst_n,
  strapIn,
  strapOut,
  doneOut
);
  input  wire       clock;
  input  wire       rst_n;
  input  wire [2:0] strapIn;
  output reg  [2:0] strapOut;
  output reg        doneOut;

  reg [2:0]                 syncA_r;
  reg [2:0]                 syncB_r;
  reg [2:0]                 syncC_r;
  reg [`SIA_STRAP_CW-1:0]   settle_r;

  // ********************************
  // three-stage sync; b and c must agree before counting
  // ********************************
  always @(posedge clock) begin
    if (!rst_n) begin
      syncA_r  <= 3'h0;
      syncB_r  <= 3'h0;
      syncC_r  <= 3'h0;
      settle_r <= {`SIA_STRAP_CW{1'b0}};
      strapOut <= 3'h0;
      doneOut  <= 1'b0;
    end else begin
      syncA_r <= strapIn;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      if (doneOut) begin
        settle_r <= settle_r;
      end else if (syncB_r != syncC_r) begin
        settle_r <= {`SIA_STRAP_CW{1'b0}};
      end else if (settle_r == `SIA_STRAP_CYC - 1) begin
        strapOut <= syncC_r;                                  // R14
        doneOut  <= 1'b1;                                     // R15
      end else begin
        settle_r <= settle_r + {{(`SIA_STRAP_CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== hdl/sia_shared_regs.v
/*
 * shared indirect-access register bank: indirect target/offset/data
 * engine, self-test control with remote clock-source push, strap decode
 * status and gpio pulldown control.
 * assumes a serial control bus front end that gives one-cycle read and
 * write strobes with an 8-bit offset; target blocks answer reads with
 * the data for the current offset in the same cycle (combinational).
 */
// Behaviour
// R1: select code routes to port0, port1, shared
// R2: code 0110 writes both ports together
// R3: auto-increment advances offset after each access
// R4: offset write strobes a read when enabled
// R5: data read re-strobes when enabled and incrementing
// R6: offset holds 8-bit register index
// R7: data write forwards byte to target
// R8: data read returns target register content
// R9: output mode static, alternating, or data-driven
// R10: pin config chooses strap or register bits
// R11: enabling self-test pushes clock source remotely
// R12: software avoids clock source 3 on older parts
// R13: enable bit starts self-test, resets to zero
// R14: address-index strap latched, then done flag
// R15: mode strap latched, then done flag
// R16: pulldown on unless output or disabled
// R17: reserved target codes do nothing, read zero; code still auto-increments the offset on their data accesses
// R18: offset wraps from ff to zero
`timescale 1ns/1ns
`include "sia_defines.vh"

module sia_shared_regs (
  clock,
  rst_n,
  regWrite,
  regRead,
  regAddr,
  regWdata,
  regRdata,
  port0Rdata,
  port1Rdata,
  sharedRdata,
  idxStrap,
  modeStrap,
  bistStrap,
  bistData,
  gpioOutMode,
  iaWrStb,
  iaRdStb,
  iaOffset,
  iaWdata,
  iaTarget,
  remWrStb,
  remWrAddr,
  remWrData,
  bistEnOut,
  bistCsrcOut,
  bistToggle,
  pulldownEn
);
  input  wire       clock;
  input  wire       rst_n;
  input  wire       regWrite;
  input  wire       regRead;
  input  wire [7:0] regAddr;
  input  wire [7:0] regWdata;
  output reg  [7:0] regRdata;
  input  wire [7:0] port0Rdata;
  input  wire [7:0] port1Rdata;
  input  wire [7:0] sharedRdata;
  input  wire [2:0] idxStrap;
  input  wire [2:0] modeStrap;
  input  wire [2:0] bistStrap;
  input  wire       bistData;
  input  wire [2:0] gpioOutMode;
  output reg        iaWrStb;
  output reg        iaRdStb;
  output reg  [7:0] iaOffset;
  output reg  [7:0] iaWdata;
  output reg  [2:0] iaTarget;
  output reg        remWrStb;
  output reg  [7:0] remWrAddr;
  output reg  [7:0] remWrData;
  output reg        bistEnOut;
  output reg  [1:0] bistCsrcOut;
  output reg        bistToggle;
  output reg  [2:0] pulldownEn;

  // ********************************
  // register storage
  // ********************************
  reg  [5:0] ctl_r;
  reg        incPend_r;
  reg  [7:0] bist_r;
  reg  [2:0] pdDis_r;
  reg        bistEnD_r;
  reg  [2:0] bsA_r;
  reg  [2:0] bsB_r;
  reg  [2:0] bsC_r;
  reg  [2:0] bistPin_r;
  reg  [2:0] gpA_r;
  reg  [2:0] gpB_r;
  reg  [2:0] gpC_r;
  reg  [2:0] gpSt_r;
  reg        bdA_r;
  reg        bdB_r;
  reg        bdC_r;

  wire [2:0] idxVal;
  wire       idxDone;
  wire [2:0] modeVal;
  wire       modeDone;

  sia_strap_latch uIdx (
    .clock    (clock),
    .rst_n    (rst_n),
    .strapIn  (idxStrap),
    .strapOut (idxVal),
    .doneOut  (idxDone)
  );

  sia_strap_latch uMode (
    .clock    (clock),
    .rst_n    (rst_n),
    .strapIn  (modeStrap),
    .strapOut (modeVal),
    .doneOut  (modeDone)
  );

  // ********************************
  // indirect decode
  // ********************************
  wire [3:0] sel     = ctl_r[`SIA_CTL_SEL_HI:`SIA_CTL_SEL_LO];
  wire       autoInc = ctl_r[`SIA_CTL_AINC];
  wire       rdEn    = ctl_r[`SIA_CTL_RDEN];
  wire       wrOff   = regWrite && (regAddr == `SIA_OFF_ADDR);
  wire       wrData  = regWrite && (regAddr == `SIA_OFF_DATA);
  wire       rdData  = regRead && (regAddr == `SIA_OFF_DATA);

  // target one-hot: bit0 port0, bit1 port1, bit2 shared
  reg  [2:0] tgtHot;
  reg  [7:0] tgtRdata;
  always @* begin
    tgtHot   = 3'h0;
    tgtRdata = 8'h00;                                         // R17
    case (sel)
      `SIA_TGT_PORT0: begin
        tgtHot   = 3'h1;                                      // R1
        tgtRdata = port0Rdata;
      end
      `SIA_TGT_PORT1: begin
        tgtHot   = 3'h2;                                      // R1
        tgtRdata = port1Rdata;
      end
      `SIA_TGT_SHARED: begin
        tgtHot   = 3'h4;                                      // R1
        tgtRdata = sharedRdata;
      end
      `SIA_TGT_BOTH: begin
        tgtHot   = 3'h3;                                      // R2
        tgtRdata = 8'h00;
      end
      default: begin
        tgtHot   = 3'h0;                                      // R17
        tgtRdata = 8'h00;
      end
    endcase
  end

  // broadcast is write-only; a read through it has no single source
  wire [2:0] rdHot = (sel == `SIA_TGT_BOTH) ? 3'h0 : tgtHot;

  // a write's step waits a cycle so its own offset stands with its strobe;
  // a data read right behind such a write still sees the old offset
  wire [7:0] offStep = {7'h00, incPend_r}
                     + {7'h00, rdData && !wrData && autoInc};

  // ********************************
  // register writes and indirect engine
  // ********************************
  always @(posedge clock) begin
    if (!rst_n) begin
      ctl_r     <= `SIA_RST_CTL;
      iaOffset  <= `SIA_RST_ADDR;
      incPend_r <= 1'b0;
      bist_r    <= `SIA_RST_BIST;
      pdDis_r   <= `SIA_RST_PD;
      iaWrStb   <= 1'b0;
      iaRdStb   <= 1'b0;
      iaWdata   <= 8'h00;
      iaTarget  <= 3'h0;
    end else begin
      iaWrStb   <= 1'b0;
      iaRdStb   <= 1'b0;
      incPend_r <= 1'b0;
      iaTarget  <= tgtHot;
      if (regWrite && regAddr == `SIA_OFF_CTL)
        ctl_r <= regWdata[5:0];
      if (regWrite && regAddr == `SIA_OFF_BIST)
        bist_r <= regWdata;
      if (regWrite && regAddr == `SIA_OFF_PDCTL)
        pdDis_r <= regWdata[2:0];
      if (wrOff) begin
        iaOffset <= regWdata;                                 // R6
        iaRdStb  <= rdEn && (rdHot != 3'h0);                  // R4
      end else begin
        iaOffset <= iaOffset + offStep;                       // R3 R18
        if (wrData) begin
          iaWdata   <= regWdata;                              // R7
          iaWrStb   <= (tgtHot != 3'h0);                      // R7
          incPend_r <= autoInc;                               // R3
        end else if (rdData && autoInc) begin
          iaRdStb <= rdEn && (rdHot != 3'h0);                 // R5
        end
      end
    end
  end

  // ********************************
  // read mux
  // ********************************
  always @(posedge clock) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `SIA_OFF_CTL:   regRdata <= {2'h0, ctl_r};
        `SIA_OFF_ADDR:  regRdata <= iaOffset;
        `SIA_OFF_DATA:  regRdata <= tgtRdata;                 // R8
        `SIA_OFF_BIST:  regRdata <= bist_r;
        `SIA_OFF_STRAP: regRdata <= {idxDone, idxVal,
                                     modeDone, modeVal};      // R14 R15
        `SIA_OFF_PDCTL: regRdata <= {5'h00, pdDis_r};
        default:        regRdata <= 8'h00;
      endcase
    end
  end

  // ********************************
  // self-test control
  // ********************************
  // strap pins pass three flops; a change counts when b and c agree
  always @(posedge clock) begin
    if (!rst_n) begin
      bsA_r     <= 3'h0;
      bsB_r     <= 3'h0;
      bsC_r     <= 3'h0;
      bistPin_r <= 3'h0;
      bdA_r     <= 1'b0;
      bdB_r     <= 1'b0;
      bdC_r     <= 1'b0;
    end else begin
      bsA_r <= bistStrap;
      bsB_r <= bsA_r;
      bsC_r <= bsB_r;
      bdA_r <= bistData;
      bdB_r <= bdA_r;
      bdC_r <= bdB_r;
      if (bsB_r == bsC_r)
        bistPin_r <= bsC_r;
    end
  end

  // effective low three bits: enable and clock source
  wire [2:0] bistEff = bist_r[`SIA_BIST_PINCFG] ? bistPin_r
                                                : bist_r[2:0]; // R10
  wire       bistEn  = bistEff[`SIA_SELF_TEST_ENABLE];                 // R13
  wire [1:0] bistCs  = bistEff[`SIA_BIST_CSRC_HI:`SIA_BIST_CSRC_LO];
  wire [1:0] oMode   = bist_r[`SIA_BIST_MODE_HI:`SIA_BIST_MODE_LO];

  always @(posedge clock) begin
    if (!rst_n) begin
      bistEnD_r   <= 1'b0;
      bistEnOut   <= 1'b0;
      bistCsrcOut <= 2'h0;
      remWrStb    <= 1'b0;
      remWrAddr   <= 8'h00;
      remWrData   <= 8'h00;
      bistToggle  <= 1'b0;
    end else begin
      bistEnD_r   <= bistEn;
      bistEnOut   <= bistEn;                                  // R13
      bistCsrcOut <= bistCs;
      // one push per enable edge; the remote side owns any retries
      remWrStb    <= bistEn && !bistEnD_r;                    // R11
      remWrAddr   <= `SIA_REM_CSRC_OFF;                       // R11
      remWrData   <= {6'h00, bistCs};                         // R11
      if (!bistEn || oMode == `SIA_OMODE_STATIC)
        bistToggle <= 1'b0;                                   // R9
      else if (oMode == `SIA_OMODE_ALT)
        bistToggle <= !bistToggle;                            // R9
      else if (bdB_r == bdC_r)
        bistToggle <= bdC_r;                                  // R9
    end
  end

  // ********************************
  // gpio pulldowns
  // ********************************
  always @(posedge clock) begin
    if (!rst_n) begin
      gpA_r      <= 3'h0;
      gpB_r      <= 3'h0;
      gpC_r      <= 3'h0;
      gpSt_r     <= 3'h0;
      pulldownEn <= 3'h0;
    end else begin
      gpA_r      <= gpioOutMode;
      gpB_r      <= gpA_r;
      gpC_r      <= gpB_r;
      if (gpB_r == gpC_r)
        gpSt_r <= gpC_r;
      pulldownEn <= ~gpSt_r & ~pdDis_r;                       // R16
    end
  end
endmodule

// ===== sim/sia_shared_regs_assertions.sv
/* port checker for the shared indirect register bank.
 * assumes one clock domain and a bind to sia_shared_regs. */
`timescale 1ns/1ns
module sia_shared_regs_assertions (
  input logic       clock,
  input logic       rst_n,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regAddr,
  input logic [7:0] regWdata,
  input logic [7:0] regRdata,
  input logic [7:0] port0Rdata,
  input logic [7:0] port1Rdata,
  input logic [7:0] sharedRdata,
  input logic       iaWrStb,
  input logic       iaRdStb,
  input logic [7:0] iaOffset,
  input logic [7:0] iaWdata,
  input logic [2:0] iaTarget,
  input logic       remWrStb,
  input logic [7:0] remWrAddr,
  input logic [7:0] remWrData,
  input logic       bistEnOut,
  input logic [1:0] bistCsrcOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadow of the control register, the checker cannot see the real one
  logic [5:0] ctl_r;
  wire [3:0] sel = ctl_r[5:2];
  wire ok = sel == 4'h1 || sel == 4'h2 || sel == 4'h5;
  wire okW = ok || sel == 4'h6;
  wire wD = regWrite && regAddr == 8'hb2;
  wire rD = regRead && !regWrite && regAddr == 8'hb2;
  wire wA = regWrite && regAddr == 8'hb1;
  wire [7:0] tgtData = sel == 4'h1 ? port0Rdata :
                       sel == 4'h2 ? port1Rdata : sharedRdata;
  wire [2:0] tgtExp = sel == 4'h1 ? 3'h1 : sel == 4'h2 ? 3'h2 :
                      sel == 4'h5 ? 3'h4 : 3'h3;
  always @(posedge clock)
    if (!rst_n) ctl_r <= 6'h00;
    else if (regWrite && regAddr == 8'hb0) ctl_r <= regWdata[5:0];
  sequence s_en_rise;
    $rose(bistEnOut);
  endsequence
  sequence s_push;
    remWrStb && remWrAddr == 8'h14 && remWrData == {6'h00, bistCsrcOut};
  endsequence
  a_wr_fwd: assert property (wD && okW |=> iaWrStb &&
    iaWdata == $past(regWdata)) else $error("write not forwarded");
  a_tgt_route: assert property (wD && okW |=>
    iaTarget == $past(tgtExp)) else $error("wrong target");
  a_rsv_quiet: assert property ((wD || rD) && !okW |=>
    !iaWrStb && !iaRdStb) else $error("reserved code strobed");
  a_rsv_zero: assert property (rD && !ok |=>
    regRdata == 8'h00) else $error("reserved read not zero");
  a_inc_step: assert property (rD && ok && ctl_r[1] &&
    !$past(wD && ctl_r[1]) |=>
    iaOffset == $past(iaOffset) + 8'h01) else $error("no increment");
  a_wr_step: assert property ((wD && okW && ctl_r[1]) ##1
    (!wA && !rD) |=> iaOffset == $past(iaOffset, 2) + 8'h01)
    else $error("no write increment");
  a_wr_addr: assert property (wD && okW &&
    !$past(wD && ctl_r[1]) |=> iaWrStb && iaOffset == $past(iaOffset))
    else $error("write offset moved");
  a_off_load: assert property (wA |=>
    iaOffset == $past(regWdata)) else $error("offset not loaded");
  a_pref_stb: assert property (wA && ctl_r[0] && ok |=>
    iaRdStb) else $error("no prefetch strobe");
  a_rd_restb: assert property (rD && ok && ctl_r[1:0] == 2'h3 |=>
    iaRdStb) else $error("no read restrobe");
  a_rd_data: assert property (rD && ok |=>
    regRdata == $past(tgtData)) else $error("wrong read data");
  a_push_once: assert property (s_en_rise |-> s_push)
    else $error("clock source not pushed");
endmodule
bind sia_shared_regs sia_shared_regs_assertions chk_u (.clock, .rst_n,
  .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .port0Rdata,
  .port1Rdata, .sharedRdata, .iaWrStb, .iaRdStb, .iaOffset, .iaWdata,
  .iaTarget, .remWrStb, .remWrAddr, .remWrData, .bistEnOut, .bistCsrcOut);

// ===== sim/sia_target_model.sv
/* three indirect target register blocks, each preset to its offset.
 * assumes combinational read at the offset, write on the strobe. */
`timescale 1ns/1ns
module sia_target_model (
  input  logic       clock,
  input  logic       iaWrStb,
  input  logic [7:0] iaOffset,
  input  logic [7:0] iaWdata,
  input  logic [2:0] iaTarget,
  output logic [7:0] port0Rdata,
  output logic [7:0] port1Rdata,
  output logic [7:0] sharedRdata
);
  logic [7:0] mem [0:2][0:255];
  initial
    for (int i = 0; i < 768; i++) mem[i / 256][i % 256] = i[7:0];
  always @(posedge clock)
    for (int t = 0; t < 3; t++)
      if (iaWrStb && iaTarget[t]) mem[t][iaOffset] <= iaWdata;
  assign port0Rdata = mem[0][iaOffset];
  assign port1Rdata = mem[1][iaOffset];
  assign sharedRdata = mem[2][iaOffset];
endmodule

// ===== sim/sia_shared_regs_tb.sv
/* self-checking bench for the shared indirect register bank.
 * assumes the target model and the bound port checker. */
`timescale 1ns/1ns
module sia_shared_regs_tb;
  logic clock = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, got;
  logic [2:0] gpioOutMode = 3'h1, bistStrap = 3'h0;
  logic bistData = 1'b0;
  wire [7:0] regRdata, p0, p1, sh, iaOffset, iaWdata, remWrAddr, remWrData;
  wire [2:0] iaTarget, pulldownEn;
  wire [1:0] bistCsrcOut;
  wire iaWrStb, iaRdStb, remWrStb, bistEnOut, bistToggle;
  logic [3:0] sels [3] = '{4'h1, 4'h2, 4'h5};
  int num_errors = 0, total_checks = 0;
  always #20 clock = ~clock;
  sia_shared_regs dut_u (.clock(clock), .rst_n(rst_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .port0Rdata(p0),
    .port1Rdata(p1), .sharedRdata(sh), .idxStrap(3'h5),
    .modeStrap(3'h3), .bistStrap(bistStrap), .bistData(bistData),
    .gpioOutMode(gpioOutMode), .iaWrStb(iaWrStb), .iaRdStb(iaRdStb),
    .iaOffset(iaOffset), .iaWdata(iaWdata), .iaTarget(iaTarget),
    .remWrStb(remWrStb), .remWrAddr(remWrAddr), .remWrData(remWrData),
    .bistEnOut(bistEnOut), .bistCsrcOut(bistCsrcOut),
    .bistToggle(bistToggle), .pulldownEn(pulldownEn));
  sia_target_model tgt_u (.clock(clock), .iaWrStb(iaWrStb),
    .iaOffset(iaOffset), .iaWdata(iaWdata), .iaTarget(iaTarget),
    .port0Rdata(p0), .port1Rdata(p1), .sharedRdata(sh));
  // ****************
  // bus and compare
  // ****************
  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    chk(regRdata, e);
  endtask
  task w_push;
    for (int i = 0; i < 10 && remWrStb !== 1'b1; i++) @(negedge clock);
  endtask
  task test_done;
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task t_reset;
    rc(8'hb0, 8'h00);
    rc(8'hb1, 8'h00);
    rc(8'hb3, 8'h08);
    rc(8'hbe, 8'h00);
    rc(8'h10, 8'h00);
  endtask
  task t_route;
    for (int s = 0; s < 3; s++) begin
      wr(8'hb0, {2'h0, sels[s], 2'h0});
      wr(8'hb1, 8'h20);
      wr(8'hb2, 8'ha0 + s[7:0]);
      rc(8'hb2, 8'ha0 + s[7:0]);
    end
    wr(8'hb0, 8'h18);
    wr(8'hb2, 8'h66);
    rc(8'hb2, 8'h00);
    for (int s = 0; s < 3; s++) begin
      wr(8'hb0, {2'h0, sels[s], 2'h0});
      rc(8'hb2, s == 2 ? 8'ha2 : 8'h66);
    end
  endtask
  task t_rsv;
    for (int c = 0; c < 16; c++)
      if (!(c inside {1, 2, 5, 6})) begin
        wr(8'hb0, {2'h0, c[3:0], 2'h0});
        wr(8'hb2, 8'h77);
        rc(8'hb2, 8'h00);
      end
    wr(8'hb0, 8'h08);
    rc(8'hb2, 8'h66);
  endtask
  task t_inc;
    wr(8'hb0, 8'h07);
    wr(8'hb1, 8'hfe);
    rc(8'hb2, 8'hfe);
    rc(8'hb2, 8'hff);
    rc(8'hb1, 8'h00);
    wr(8'hb2, 8'h31);
    rc(8'hb1, 8'h01);
    wr(8'hb1, 8'h00);
    rc(8'hb2, 8'h31);
  endtask
  task t_bist;
    wr(8'hb3, 8'h45);
    w_push;
    chk({7'h0, remWrStb}, 8'h01);
    chk(remWrData, 8'h02);
    chk(remWrAddr, 8'h14);
    chk({7'h0, bistEnOut}, 8'h01);
    got = {7'h0, bistToggle};
    @(negedge clock);
    chk({7'h0, bistToggle}, got ^ 8'h01);
    wr(8'hb3, 8'h05);
    repeat (4) @(negedge clock);
    got = {7'h0, bistToggle};
    @(negedge clock);
    chk({7'h0, bistToggle}, got);
    rc(8'hb3, 8'h05);
    wr(8'hb3, 8'h85);
    bistData = 1'b1;
    repeat (6) @(negedge clock);
    chk({7'h0, bistToggle}, 8'h01);
    bistData = 1'b0;
    repeat (6) @(negedge clock);
    chk({7'h0, bistToggle}, 8'h00);
    wr(8'hb3, 8'h08);
    repeat (2) @(negedge clock);
    chk({7'h0, bistEnOut}, 8'h00);
    bistStrap = 3'h3;
    w_push;
    chk({7'h0, remWrStb}, 8'h01);
    chk(remWrData, 8'h01);
    chk({7'h0, bistEnOut}, 8'h01);
  endtask
  task t_pd;
    chk({5'h0, pulldownEn}, 8'h06);
    wr(8'hbe, 8'h02);
    gpioOutMode = 3'h4;
    repeat (6) @(negedge clock);
    chk({5'h0, pulldownEn}, 8'h01);
    rc(8'hbe, 8'h02);
    rc(8'hb8, 8'hdb);
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    t_reset;
    t_route;
    t_rsv;
    t_inc;
    t_bist;
    t_pd;
    test_done;
  end
  // ****************
  // watchdog, about fourteen times the expected run
  // ****************
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    test_done;
  end
endmodule
